// ===== hw/qdbl_map.vh
/*
  Constants for the host-side byte-load controller of a quad 14-bit DAC.
  Assumes a 250 MHz system clock and the device's parallel pins driven directly.
*/
// Notes on behaviour
// - Host drives top six data lines low
// - Byte select low upper, high lower
// - Upper six bits on lowest data lines
// - Lower byte written before upper byte
// - Host drives latch load from decode
// - Channel address from host low address
`ifndef QDBL_MAP_VH
`define QDBL_MAP_VH
`define QDBL_CODE_W 14
`define QDBL_LO_W 8
`define QDBL_HI_W 6
`define QDBL_DATA_W 14
`define QDBL_LO_LSB 0
`define QDBL_LO_MSB 7
`define QDBL_HI_LSB 8
`define QDBL_HI_MSB 13
`define QDBL_BSEL_LOWER 1'b1
`define QDBL_BSEL_UPPER 1'b0
`define QDBL_PIN_IDLE 1'b1
`define QDBL_ADDR_RST 1'b0
`define QDBL_DATA_RST 14'h0000
`define QDBL_CODE_RST 14'h0000
`define QDBL_SETUP_NS 20
`define QDBL_STROBE_NS 40
`define QDBL_HOLD_NS 20
`define QDBL_LOAD_NS 40
`define QDBL_CLK_NS 4
`define QDBL_CYC(ns) (((ns) + `QDBL_CLK_NS - 1) / `QDBL_CLK_NS)
`endif

// ===== hw/qdbl_host.v
/*
  Host controller that writes 14-bit codes to a quad DAC in byte-loading mode.
  Assumes the DAC's write, select, byte-select, address, data and load pins
  are wired straight to the outputs below and sampled by the device.
*/
`timescale 1ns/10ps
`default_nettype none
`include "qdbl_map.vh"
module qdbl_host #(
  parameter SETUP_CYC = `QDBL_CYC(`QDBL_SETUP_NS),
  parameter STROBE_CYC = `QDBL_CYC(`QDBL_STROBE_NS),
  parameter HOLD_CYC = `QDBL_CYC(`QDBL_HOLD_NS),
  parameter LOAD_CYC = `QDBL_CYC(`QDBL_LOAD_NS)
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire req_valid_i,
  input wire [13:0] req_code_i,
  input wire [2:0] req_chan_i,
  input wire req_load_i,
  input wire load_only_i,
  output reg req_ready_o,
  output reg done_o,
  output reg [13:0] dac_data_o,
  output reg byte_half_select_o,
  output reg channel_addr_bit0_o,
  output reg channel_addr_bit1_o,
  output reg channel_addr_bit2_o,
  output reg dev_sel_n_o,
  output reg write_n_o,
  output reg dac_latch_load_n_o
);
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_SET = 6'h02;
  localparam [5:0] S_STB = 6'h04;
  localparam [5:0] S_HOLD = 6'h08;
  localparam [5:0] S_LOAD = 6'h10;
  localparam [5:0] S_DONE = 6'h20;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;
  reg upper_r;
  reg upper_nxt;
  reg load_r;
  reg load_nxt;
  reg [13:0] code_r;
  reg [13:0] code_nxt;
  // Next values of the registered outputs
  reg ready_nxt;
  reg done_nxt;
  reg [13:0] data_nxt;
  reg bsel_nxt;
  reg [2:0] chan_nxt;
  reg sel_n_nxt;
  reg write_n_nxt;
  reg load_n_nxt;

  // Phase length in clocks; a zero or negative setting still gives one clock
  function [7:0] cyc8;
    input integer n;
    begin
      cyc8 = (n < 1) ? 8'h01 : n[7:0];
    end
  endfunction

  // True in the last clock of a timed phase
  function last_cyc;
    input [7:0] cnt;
    begin
      last_cyc = (cnt == 8'h01);
    end
  endfunction

  // Lower byte on the eight low data lines; top six lines stay low
  function [13:0] lo_pins;
    input [13:0] code;
    begin
      lo_pins = {6'h00, code[`QDBL_LO_MSB:`QDBL_LO_LSB]};
    end
  endfunction

  // Upper six bits right-justified on the lowest data lines
  function [13:0] hi_pins;
    input [13:0] code;
    begin
      hi_pins = {8'h00, code[`QDBL_HI_MSB:`QDBL_HI_LSB]};
    end
  endfunction

  // Next-state and next-output logic; every output except done_o holds unless a phase changes it
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    upper_nxt = upper_r;
    load_nxt = load_r;
    code_nxt = code_r;
    ready_nxt = req_ready_o;
    done_nxt = 1'b0;
    data_nxt = dac_data_o;
    bsel_nxt = byte_half_select_o;
    chan_nxt = {channel_addr_bit2_o, channel_addr_bit1_o, channel_addr_bit0_o};
    sel_n_nxt = dev_sel_n_o;
    write_n_nxt = write_n_o;
    load_n_nxt = dac_latch_load_n_o;
    case (state_r)
      S_IDLE: begin
        ready_nxt = 1'b1;
        if (req_valid_i && req_ready_o) begin
          ready_nxt = 1'b0;
          code_nxt = req_code_i;
          load_nxt = req_load_i | load_only_i;
          chan_nxt = req_chan_i;
          if (load_only_i) begin
            // Latch transfer alone, no byte writes
            load_n_nxt = 1'b0;
            cnt_nxt = cyc8(LOAD_CYC);
            state_nxt = S_LOAD;
          end else begin
            // Lower byte goes first
            upper_nxt = 1'b0;
            bsel_nxt = `QDBL_BSEL_LOWER;
            data_nxt = lo_pins(req_code_i);
            cnt_nxt = cyc8(SETUP_CYC);
            state_nxt = S_SET;
          end
        end
      end
      S_SET: begin
        sel_n_nxt = 1'b0;
        if (last_cyc(cnt_r)) begin
          write_n_nxt = 1'b0;
          cnt_nxt = cyc8(STROBE_CYC);
          state_nxt = S_STB;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      S_STB: begin
        if (last_cyc(cnt_r)) begin
          write_n_nxt = 1'b1;
          cnt_nxt = cyc8(HOLD_CYC);
          state_nxt = S_HOLD;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      S_HOLD: begin
        if (last_cyc(cnt_r)) begin
          sel_n_nxt = 1'b1;
          if (!upper_r) begin
            // Upper part follows once the lower byte is in
            upper_nxt = 1'b1;
            bsel_nxt = `QDBL_BSEL_UPPER;
            data_nxt = hi_pins(code_r);
            cnt_nxt = cyc8(SETUP_CYC);
            state_nxt = S_SET;
          end else if (load_r) begin
            load_n_nxt = 1'b0;
            cnt_nxt = cyc8(LOAD_CYC);
            state_nxt = S_LOAD;
          end else begin
            state_nxt = S_DONE;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      S_LOAD: begin
        if (last_cyc(cnt_r)) begin
          load_n_nxt = 1'b1;
          state_nxt = S_DONE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      S_DONE: begin
        done_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // State and output registers; pins come straight from these flip-flops
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      cnt_r <= 8'h00;
      upper_r <= 1'b0;
      load_r <= 1'b0;
      code_r <= `QDBL_CODE_RST;
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      dac_data_o <= `QDBL_DATA_RST;
      byte_half_select_o <= `QDBL_BSEL_LOWER;
      channel_addr_bit0_o <= `QDBL_ADDR_RST;
      channel_addr_bit1_o <= `QDBL_ADDR_RST;
      channel_addr_bit2_o <= `QDBL_ADDR_RST;
      dev_sel_n_o <= `QDBL_PIN_IDLE;
      write_n_o <= `QDBL_PIN_IDLE;
      dac_latch_load_n_o <= `QDBL_PIN_IDLE;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      upper_r <= upper_nxt;
      load_r <= load_nxt;
      code_r <= code_nxt;
      req_ready_o <= ready_nxt;
      done_o <= done_nxt;
      dac_data_o <= data_nxt;
      byte_half_select_o <= bsel_nxt;
      channel_addr_bit0_o <= chan_nxt[0];
      channel_addr_bit1_o <= chan_nxt[1];
      channel_addr_bit2_o <= chan_nxt[2];
      dev_sel_n_o <= sel_n_nxt;
      write_n_o <= write_n_nxt;
      dac_latch_load_n_o <= load_n_nxt;
    end
  end
endmodule // qdbl_host
`default_nettype wire

// ===== tb/qdbl_chk_properties.sv
/* Pin checker for qdbl_host.
   Bound to every qdbl_host instance; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module qdbl_chk(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic byte_half_select_o,
  input wire logic dev_sel_n_o,
  input wire logic write_n_o,
  input wire logic dac_latch_load_n_o,
  input wire logic channel_addr_bit0_o,
  input wire logic channel_addr_bit1_o,
  input wire logic channel_addr_bit2_o,
  input wire logic [13:0] dac_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic lo_done_r;
  logic wr_q_r;
  // Remembers whether the last finished write strobe carried the lower byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_done_r <= 1'b0;
      wr_q_r <= 1'b1;
    end else begin
      wr_q_r <= write_n_o;
      if (write_n_o && !wr_q_r) lo_done_r <= byte_half_select_o;
    end
  end
  chk_top_low: assert property (dac_data_o[13:8] == 6'h0)
    else $error("top data lines not low");
  chk_write_hold: assert property (!write_n_o |-> !dev_sel_n_o && $stable(byte_half_select_o))
    else $error("byte select moved in write");
  chk_upper_just: assert property (!byte_half_select_o |-> dac_data_o[13:6] == 8'h0)
    else $error("upper bits not on lowest lines");
  chk_lower_first: assert property ($fell(write_n_o) && !byte_half_select_o |-> lo_done_r)
    else $error("upper written before lower");
  chk_load_idle: assert property (!dac_latch_load_n_o |-> dev_sel_n_o && write_n_o)
    else $error("load during write");
  chk_chan_hold: assert property (!dev_sel_n_o |->
    $stable({channel_addr_bit2_o, channel_addr_bit1_o, channel_addr_bit0_o})) else $error("address moved");
  cover property ($fell(write_n_o) && !byte_half_select_o);
  cover property ($fell(dac_latch_load_n_o));
  cover property ($fell(dev_sel_n_o) && channel_addr_bit2_o);
endmodule // qdbl_chk
bind qdbl_host qdbl_chk u_chk(.clk_i, .rst_n_i, .byte_half_select_o, .dev_sel_n_o, .write_n_o,
  .dac_latch_load_n_o, .channel_addr_bit0_o, .channel_addr_bit1_o, .channel_addr_bit2_o, .dac_data_o);
`default_nettype wire

// ===== tb/qdbl_dac_model.sv
/* Behavioural quad DAC in byte-load mode.
   Driven by the host pins; holds input registers and latches. */
`timescale 1ns/10ps
`default_nettype none
module qdbl_dac_model(
  input wire logic sel_n_i,
  input wire logic wr_n_i,
  input wire logic bsel_i,
  input wire logic ld_n_i,
  input wire logic [2:0] ch_i,
  input wire logic [13:0] d_i
);
  logic [13:0] in_r [4];
  logic [13:0] dac_r [4];
  // Input registers take the addressed half at the end of the write strobe
  always @(posedge wr_n_i) begin
    if (!sel_n_i) begin
      for (int k = 0; k < 4; k++) begin
        if (ch_i[2] || ch_i[1:0] == 2'(k)) begin
          if (bsel_i) in_r[k][7:0] = d_i[7:0];
          else in_r[k][13:8] = d_i[5:0];
          if (!ld_n_i) dac_r[k] = in_r[k];
        end
      end
    end
  end
  // A falling load moves every input register into its latch
  always @(negedge ld_n_i) begin
    for (int k = 0; k < 4; k++) dac_r[k] = in_r[k];
  end
endmodule // qdbl_dac_model
`default_nettype wire

// ===== tb/tb.sv
/* Self-checking bench for qdbl_host with a DAC model. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 0, rst_n_i = 0, req_valid_i = 0, req_load_i = 0, load_only_i = 0;
  logic [13:0] req_code_i = 0;
  logic [2:0] req_chan_i = 0;
  wire logic req_ready_o, done_o, bsel, a0, a1, a2, sel_n, wr_n, ld_n;
  wire logic [13:0] data;
  int err_total = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  qdbl_host DUT(.clk_i, .rst_n_i, .req_valid_i, .req_code_i, .req_chan_i, .req_load_i, .load_only_i,
    .req_ready_o, .done_o, .dac_data_o(data), .byte_half_select_o(bsel), .channel_addr_bit0_o(a0),
    .channel_addr_bit1_o(a1), .channel_addr_bit2_o(a2), .dev_sel_n_o(sel_n), .write_n_o(wr_n),
    .dac_latch_load_n_o(ld_n));
  qdbl_dac_model M(.sel_n_i(sel_n), .wr_n_i(wr_n), .bsel_i(bsel), .ld_n_i(ld_n), .ch_i({a2, a1, a0}),
    .d_i(data));
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [13:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [13:0] c, input logic [2:0] ch, input logic ld, lo);
    int n;
    {req_code_i, req_chan_i, req_load_i, load_only_i, req_valid_i} = {c, ch, ld, lo, 1'b1};
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (req_ready_o !== 1'b0 && n < 200);
    req_valid_i = 0;
    n = 0;
    while (done_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (done_o !== 1'b1) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, done_o, 1'b1);
      finish_test();
    end
  endtask
  task automatic t_each();
    for (int k = 0; k < 4; k++) begin
      req(14'h3c5a ^ 14'(k), 3'(k), 1'b1, 1'b0);
      cmp(M.dac_r[k], 14'h3c5a ^ 14'(k));
    end
  endtask
  task automatic t_all();
    req(14'h2b71, 3'h6, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) cmp(M.dac_r[k], 14'h2b71);
  endtask
  task automatic t_defer();
    req(14'h0f0f, 3'h1, 1'b0, 1'b0);
    cmp(M.dac_r[1], 14'h2b71);
    req(14'h0, 3'h0, 1'b0, 1'b1);
    cmp(M.dac_r[1], 14'h0f0f);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1;
    repeat (2) @(posedge clk_i);
    #1;
    t_each();
    t_all();
    t_defer();
    finish_test();
  end
endmodule // tb
`default_nettype wire
